// >>> inc/sbsf_pkg.sv
// Constants and types shared by the serial buffer-status block
package sbsf_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] A_STAT = 3'h0;
	localparam logic [2:0] A_CON1 = 3'h1;
	localparam logic [2:0] A_DATA = 3'h2;
	localparam logic [2:0] A_MODE = 3'h3;
	localparam logic [2:0] A_ISTAT = 3'h4;
	localparam logic [2:0] A_ICLR = 3'h5;
	localparam logic [2:0] A_IEN = 3'h6;
	// Status and control field positions
	localparam int B_EN = 15;
	localparam int B_CNT = 8;
	localparam int B_SRMPT = 7;
	localparam int B_ROV = 6;
	localparam int B_RXEMPTY = 5;
	localparam int B_TBF = 1;
	localparam int B_RBF = 0;
	localparam int B_CLKPINDIS = 12;
	localparam int B_DISSDO = 11;
	localparam int B_WIDE = 10;
	localparam int B_SSEN = 7;
	localparam int B_CKP = 6;
	localparam int B_MSTEN = 5;
	localparam int B_ENH = 0;
	// Interrupt event bits
	localparam int E_TXFREE = 0;
	localparam int E_RXDATA = 1;
	localparam int E_OVF = 2;
	localparam int NEV = 3;
	// Reset values
	localparam logic [15:0] STAT_RST = 16'h0000;
	localparam logic [15:0] CON1_RST = 16'h0000;
	// Master serial clock timing
	localparam int CLK_NS = 8;
	localparam int SCK_HALF_NS = 80;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS / CLK_NS < 1) ? 1 :
		SCK_HALF_NS / CLK_NS;
	typedef enum logic [0:0] {
		SB_IDLE = 1'b0,
		SB_SHIFT = 1'b1
	} sbsf_state_t;
endpackage

// >>> src/sbsf_fifo.sv
// Holding buffer with a selectable single-entry or full-depth limit
`timescale 1ns/10ps
module sbsf_fifo #(
	parameter int W = 16,
	parameter int D = 4,
	parameter int CW = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Fill side
	input wire logic pushEn,
	input wire logic [W-1:0] pushData,
	// Drain side
	input wire logic popEn,
	output logic [W-1:0] headData,
	// Depth select and state
	input wire logic limitOne,
	output logic [CW-1:0] count,
	output logic full,
	output logic empty
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] rdPtr_reg, rdPtr_next, wrPtr_reg, wrPtr_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic doPush, doPop;

	assign count = cnt_reg;
	assign empty = (cnt_reg == '0);
	assign full = limitOne ? !empty : (cnt_reg >= CW'(D));
	assign headData = mem[rdPtr_reg];
	assign doPush = pushEn && !full;
	assign doPop = popEn && !empty;

	always_comb begin
		rdPtr_next = rdPtr_reg;
		wrPtr_next = wrPtr_reg;
		cnt_next = cnt_reg;
		if (doPush) begin
			wrPtr_next = (wrPtr_reg == AW'(D - 1)) ? '0 : wrPtr_reg + 1'b1;
		end
		if (doPop) begin
			rdPtr_next = (rdPtr_reg == AW'(D - 1)) ? '0 : rdPtr_reg + 1'b1;
		end
		if (doPush && !doPop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (doPop && !doPush) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdPtr_reg <= '0;
			wrPtr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			rdPtr_reg <= rdPtr_next;
			wrPtr_reg <= wrPtr_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (doPush) begin
			mem[wrPtr_reg] <= pushData;
		end
	end
endmodule

// >>> src/sbsf_top.sv
// Serial port with transmit and receive buffer-status flags
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
//
// Function
// RL1 - Transmit-full flag sits at status bit 1; set while buffer full.
// RL2 - Standard mode: data window write loads buffer and sets transmit-full.
// RL3 - Standard mode: move into shift register clears transmit-full.
// RL4 - Enhanced mode: transmit-full set only when last free entry is written.
// RL5 - Enhanced mode: transmit-full clears when any entry becomes free.
// RL6 - Receive-full flag sits at status bit 0; set while buffer full.
// RL7 - Standard mode: shift register transfer sets receive-full.
// RL8 - Standard mode: data window read clears receive-full.
// RL9 - Enhanced mode: receive-full set when transfer fills last entry.
// RL10 - Enhanced mode: receive-full clears when any entry becomes free.
// RL11 - Word arriving with unread data is discarded, overflow flag set; enhanced mode keeps it unless all entries are unread.
// RL12 - Mode control picks single-entry or multi-entry buffering.
// RL13 - Master with clock-pin-disable set stops driving the clock pin.
module sbsf_top
	import sbsf_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int HALF_CYC = SCK_HALF_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [2:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// Interrupt
	output logic irq,
	// Serial link
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe_n,
	input wire logic sdiIn,
	output logic sdoOut,
	output logic sdoOe_n,
	input wire logic ssIn_n
);
	localparam int CW = $clog2(DEPTH + 1);

	// Register state
	logic en_reg, en_next, rov_reg, rov_next, enh_reg, enh_next;
	logic [15:0] con1_reg, con1_next;
	logic [NEV-1:0] ist_reg, ist_next, ien_reg, ien_next, ev;
	logic [15:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	// Synchronisers
	logic sckS1, sckS2, sckS3, sdiS1, sdiS2, ssS1, ssS2;
	// Engine state
	sbsf_state_t st_reg, st_next;
	logic [15:0] sr_reg, sr_next;
	logic [3:0] bit_reg, bit_next;
	logic samp_reg, samp_next;
	logic [15:0] div_reg, div_next;
	logic sck_reg, sck_next, sckOe_reg, sckOe_next;
	logic sdo_reg, sdo_next, sdoOe_reg, sdoOe_next;
	// Buffer handshakes
	logic txWr, txPop, txFull, txEmpty, rxPush, rxPop, rxFull, rxEmpty;
	logic [15:0] txHead, rxHead, rxWord;
	logic [CW-1:0] txCount, rxCount;
	logic master, wide, ckp, selected, tick, lead, trail, sEdge, ovf;

	assign master = con1_reg[B_MSTEN];
	assign wide = con1_reg[B_WIDE];
	assign ckp = con1_reg[B_CKP];
	assign selected = !con1_reg[B_SSEN] || !ssS2;

	// Link inputs pass two flops before use
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sckS1 <= 1'b0;
			sckS2 <= 1'b0;
			sckS3 <= 1'b0;
			sdiS1 <= 1'b0;
			sdiS2 <= 1'b0;
			ssS1 <= 1'b1;
			ssS2 <= 1'b1;
		end else begin
			sckS1 <= sckIn;
			sckS2 <= sckS1;
			sckS3 <= sckS2;
			sdiS1 <= sdiIn;
			sdiS2 <= sdiS1;
			ssS1 <= ssIn_n;
			ssS2 <= ssS1;
		end
	end

	// Data window access
	// RL2 RL4 write loads
	assign txWr = regWr && regAddr == A_DATA;
	// RL8 RL10 read drains
	assign rxPop = regRd && regAddr == A_DATA && !rxEmpty;

	// RL12 depth follows mode
	sbsf_fifo #(.W(16), .D(DEPTH), .CW(CW)) txBuf (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pushEn(txWr),
		.pushData(regWdata),
		.popEn(txPop),
		.headData(txHead),
		.limitOne(!enh_reg),
		.count(txCount),
		.full(txFull),
		.empty(txEmpty)
	);

	sbsf_fifo #(.W(16), .D(DEPTH), .CW(CW)) rxBuf (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pushEn(rxPush),
		.pushData(rxWord),
		.popEn(rxPop),
		.headData(rxHead),
		.limitOne(!enh_reg),
		.count(rxCount),
		.full(rxFull),
		.empty(rxEmpty)
	);

	// Clock edge detection, master divider or slave sampling
	assign tick = (div_reg == 16'(HALF_CYC - 1));
	assign sEdge = selected && (sckS2 != sckS3);
	always_comb begin
		if (master) begin
			lead = st_reg == SB_SHIFT && tick && sck_reg == ckp;
			trail = st_reg == SB_SHIFT && tick && sck_reg != ckp;
		end else begin
			lead = sEdge && sckS2 != ckp;
			trail = sEdge && sckS2 == ckp;
		end
	end

	assign rxWord = wide ? {sr_reg[14:0], samp_reg} :
		{8'h00, sr_reg[6:0], samp_reg};

	// Shift engine
	always_comb begin
		st_next = st_reg;
		sr_next = sr_reg;
		bit_next = bit_reg;
		samp_next = samp_reg;
		div_next = '0;
		sck_next = ckp;
		txPop = 1'b0;
		rxPush = 1'b0;
		case (st_reg)
			SB_IDLE: begin
				bit_next = '0;
				if (en_reg && !txEmpty) begin
					// RL3 RL5 move frees entry
					txPop = 1'b1;
					sr_next = txHead;
					st_next = SB_SHIFT;
				end
			end
			SB_SHIFT: begin
				if (master) begin
					div_next = tick ? '0 : div_reg + 1'b1;
					sck_next = tick ? !sck_reg : sck_reg;
				end
				if (lead) begin
					samp_next = sdiS2;
				end
				if (trail) begin
					sr_next = {sr_reg[14:0], samp_reg};
					bit_next = bit_reg + 1'b1;
					if (bit_reg == (wide ? 4'hf : 4'h7)) begin
						// RL7 RL9 word into receive buffer
						rxPush = 1'b1;
						st_next = SB_IDLE;
					end
				end
				if (!en_reg || (!master && !selected)) begin
					st_next = SB_IDLE;
				end
			end
			default: st_next = SB_IDLE;
		endcase
	end

	// RL11 receive buffer full, word discarded
	assign ovf = rxPush && rxFull;

	// Pin drivers
	always_comb begin
		sdo_next = wide ? sr_next[15] : sr_next[7];
		// RL13 clock pin released
		sckOe_next = !(en_reg && master && !con1_reg[B_CLKPINDIS]);
		sdoOe_next = !(en_reg && !con1_reg[B_DISSDO] && (master || selected));
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= SB_IDLE;
			sr_reg <= '0;
			bit_reg <= '0;
			samp_reg <= 1'b0;
			div_reg <= '0;
			sck_reg <= 1'b0;
			sckOe_reg <= 1'b1;
			sdo_reg <= 1'b0;
			sdoOe_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			sr_reg <= sr_next;
			bit_reg <= bit_next;
			samp_reg <= samp_next;
			div_reg <= div_next;
			sck_reg <= sck_next;
			sckOe_reg <= sckOe_next;
			sdo_reg <= sdo_next;
			sdoOe_reg <= sdoOe_next;
		end
	end

	assign sckOut = sck_reg;
	assign sckOe_n = sckOe_reg;
	assign sdoOut = sdo_reg;
	assign sdoOe_n = sdoOe_reg;

	// Register writes, interrupts and read data
	assign ev = {ovf, rxPush && !rxFull, txPop};
	always_comb begin
		en_next = en_reg;
		enh_next = enh_reg;
		con1_next = con1_reg;
		ien_next = ien_reg;
		rov_next = rov_reg;
		ist_next = ist_reg;
		rdata_next = '0;
		if (regWr && regAddr == A_STAT) begin
			en_next = regWdata[B_EN];
			rov_next = rov_reg && regWdata[B_ROV];
		end else if (regWr && regAddr == A_CON1) begin
			con1_next = regWdata & 16'h1fff;
		end else if (regWr && regAddr == A_MODE) begin
			enh_next = regWdata[B_ENH];
		end else if (regWr && regAddr == A_ICLR) begin
			ist_next = ist_reg & ~regWdata[NEV-1:0];
		end else if (regWr && regAddr == A_IEN) begin
			ien_next = regWdata[NEV-1:0];
		end
		// Hardware set wins over clear
		ist_next = ist_next | ev;
		if (ovf) begin
			rov_next = 1'b1;
		end
		if (regRd && regAddr == A_STAT) begin
			rdata_next[B_EN] = en_reg;
			rdata_next[B_CNT +: 3] = 3'(master ? txCount : rxCount);
			rdata_next[B_SRMPT] = st_reg == SB_IDLE;
			rdata_next[B_ROV] = rov_reg;
			rdata_next[B_RXEMPTY] = rxEmpty;
			// RL1 transmit-full bit
			rdata_next[B_TBF] = txFull;
			// RL6 receive-full bit
			rdata_next[B_RBF] = rxFull;
		end else if (regRd && regAddr == A_CON1) begin
			rdata_next = con1_reg;
		end else if (regRd && regAddr == A_DATA) begin
			rdata_next = rxHead;
		end else if (regRd && regAddr == A_MODE) begin
			rdata_next[B_ENH] = enh_reg;
		end else if (regRd && regAddr == A_ISTAT) begin
			rdata_next[NEV-1:0] = ist_reg;
		end else if (regRd && regAddr == A_IEN) begin
			rdata_next[NEV-1:0] = ien_reg;
		end
		irq_next = |(ist_next & ien_next);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_reg <= STAT_RST[B_EN];
			rov_reg <= STAT_RST[B_ROV];
			enh_reg <= 1'b0;
			con1_reg <= CON1_RST;
			ist_reg <= '0;
			ien_reg <= '0;
			rdata_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			rov_reg <= rov_next;
			enh_reg <= enh_next;
			con1_reg <= con1_next;
			ist_reg <= ist_next;
			ien_reg <= ien_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end

	assign regRdata = rdata_reg;
	assign irq = irq_reg;

	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	AST_TBF_BIT: assert property ( // RL1
		regRd && regAddr == A_STAT |=> regRdata[1] == $past(txFull))
		else $error("transmit-full status bit wrong");
	AST_TBF_SET_STD: assert property ( // RL2
		!enh_reg && txWr && txEmpty && !txPop |=> txFull)
		else $error("write did not set transmit-full");
	AST_TBF_CLR_STD: assert property ( // RL3
		!enh_reg && txPop && !txWr && !regWr |=> !txFull ##1 !txFull
		or txWr)
		else $error("move did not clear transmit-full");
	AST_TBF_SET_ENH: assert property ( // RL4
		enh_reg && txWr && !txFull && !txPop
		|=> txFull == ($past(txCount) == CW'(DEPTH - 1)))
		else $error("enhanced transmit-full set wrong");
	AST_TBF_CLR_ENH: assert property ( // RL5
		enh_reg && txFull && txPop && !regWr |=> !txFull)
		else $error("freed entry left transmit-full set");
	AST_RBF_BIT: assert property ( // RL6
		regRd && regAddr == A_STAT |=> regRdata[0] == $past(rxFull))
		else $error("receive-full status bit wrong");
	AST_RBF_SET_STD: assert property ( // RL7
		!enh_reg && rxPush && rxEmpty && !regWr |=> rxFull)
		else $error("transfer did not set receive-full");
	AST_RBF_CLR_STD: assert property ( // RL8
		!enh_reg && rxPop && !rxPush && !regWr
		|=> !rxFull && regRdata == $past(rxHead))
		else $error("read did not clear receive-full");
	AST_RBF_SET_ENH: assert property ( // RL9
		enh_reg && rxPush && !rxFull && !rxPop && !regWr
		|=> rxFull == ($past(rxCount) == CW'(DEPTH - 1)))
		else $error("enhanced receive-full set wrong");
	AST_RBF_CLR_ENH: assert property ( // RL10
		enh_reg && rxFull && rxPop && !regWr |=> !rxFull)
		else $error("freed entry left receive-full set");
	AST_OVF: assert property ( // RL11
		rxPush && rxFull && !rxPop
		|=> rov_reg && ist_reg[E_OVF] && rxCount == $past(rxCount))
		else $error("overflow not flagged or word kept");
	AST_MODE_LIMIT: assert property ( // RL12
		!enh_reg && txWr && !txEmpty && !txPop
		|=> txCount == $past(txCount))
		else $error("standard mode accepted a second entry");
	AST_SCK_REL: assert property ( // RL13
		master && con1_reg[B_CLKPINDIS] && !regWr |=> sckOe_n [*2])
		else $error("clock pin still driven when disabled");
endmodule

// >>> tb/sbsf_slave_model.sv
// Far-side serial device: shifts back what it holds, MSB first
`timescale 1ns/10ps
module sbsf_slave_model (
	// Control from the bench
	input wire logic loadEn,
	input wire logic [15:0] preload,
	// Serial pins
	input wire logic sckPin,
	input wire logic sdoOut,
	input wire logic sdoOe_n,
	output logic sdiIn,
	// Word held, the last word received once a frame ends
	output logic [15:0] seen
);
	logic [15:0] sr = 16'h0000;
	logic bitIn = 1'b0;
	// Released data line gives the inverse of the last bit
	always @(posedge sckPin) begin
		bitIn <= sdoOe_n ? ~bitIn : sdoOut;
	end
	always @(negedge sckPin or posedge loadEn) begin
		if (loadEn) begin
			sr <= preload;
		end else begin
			sr <= {sr[14:0], bitIn};
		end
	end
	assign sdiIn = sr[15];
	assign seen = sr;
endmodule

// >>> tb/tb.sv
// Self-checking bench for the serial buffer-status block
`timescale 1ns/10ps
module tb;
	import sbsf_pkg::*;
	localparam int DEP = 4;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdata;
	logic irq, sckOut, sckOe_n, sdoOut, sdoOe_n, sdiIn, sckPin;
	logic loadEn = 1'b0;
	logic [15:0] seen;
	logic [15:0] rdv;
	// Rows: enhanced, writes, tx full, tx count
	logic [7:0] rows [5] = '{8'h19, 8'h29, 8'h91, 8'hb3, 8'hcc};
	int err_count = 0;
	int comparisons = 0;
	// Released clock pin is pulled low
	assign sckPin = sckOe_n ? 1'b0 : sckOut;
	always #4 sys_clk = ~sys_clk;
	sbsf_top #(.DEPTH(DEP)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .irq(irq), .sckIn(1'b0),
		.sckOut(sckOut), .sckOe_n(sckOe_n), .sdiIn(sdiIn),
		.sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .ssIn_n(1'b1));
	sbsf_slave_model u_far (.loadEn(loadEn), .preload(16'hc3a5),
		.sckPin(sckPin), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n),
		.sdiIn(sdiIn), .seen(seen));
	task automatic results();
		$display("comparisons %0d, errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task automatic doReset();
		arst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
		@(posedge sys_clk);
	endtask
	task automatic pollBit(input logic [2:0] a, input int b);
		int i;
		i = 0;
		rdv = 16'h0000;
		while (rdv[b] !== 1'b1 && i < 1000) begin
			rd(a, rdv);
			i++;
		end
		if (i >= 1000) begin
			err_count++;
			results();
		end
	endtask
	initial begin
		for (int r = 0; r < 5; r++) begin
			doReset();
			wr(A_MODE, 16'(rows[r][7]));
			wr(A_CON1, 16'h0420);
			for (int k = 0; k < rows[r][6:4]; k++) begin
				wr(A_DATA, 16'h0100 + 16'(k));
			end
			rd(A_STAT, rdv);
			chk("tx full", 16'(rows[r][3]), 16'(rdv[B_TBF]));
			chk("tx count", 16'(rows[r][2:0]), 16'(rdv[10:8]));
		end
		// Reset in mid-run returns control one and the status full flags to their reset values
		doReset();
		rd(A_CON1, rdv);
		chk("control one", CON1_RST, rdv);
		rd(A_STAT, rdv);
		chk("full flags", 16'h0000, 16'(rdv[1:0]));
		rd(3'h7, rdv);
		chk("unmapped", 16'h0000, rdv);
		chk("clock pin released", 16'h0001, 16'(sckOe_n));
		chk("irq", 16'h0000, 16'(irq));
		// Standard mode, master driving the clock pin
		doReset();
		loadEn <= 1'b1;
		@(posedge sys_clk);
		loadEn <= 1'b0;
		wr(A_IEN, 16'h0002);
		wr(A_CON1, 16'h0420);
		wr(A_STAT, 16'h8000);
		wr(A_DATA, 16'h1234);
		rd(A_STAT, rdv);
		chk("tx full moved", 16'h0000, 16'(rdv[B_TBF]));
		chk("clock pin driven", 16'h0000, 16'(sckOe_n));
		pollBit(A_ISTAT, E_RXDATA);
		chk("tx moved event", 16'h0003, rdv & 16'h0003);
		chk("irq raised", 16'h0001, 16'(irq));
		rd(A_STAT, rdv);
		chk("rx full set", 16'h0001, 16'(rdv[B_RBF]));
		rd(A_DATA, rdv);
		chk("rx word", 16'hc3a5, rdv);
		chk("far side word", 16'h1234, seen);
		rd(A_STAT, rdv);
		chk("rx full read", 16'h0000, 16'(rdv[B_RBF]));
		// Masked event, then a word arriving over unread data
		wr(A_ICLR, 16'h0007);
		wr(A_IEN, 16'h0000);
		wr(A_DATA, 16'h1111);
		pollBit(A_ISTAT, E_RXDATA);
		chk("irq masked", 16'h0000, 16'(irq));
		wr(A_ICLR, 16'h0007);
		wr(A_DATA, 16'h2222);
		pollBit(A_ISTAT, E_OVF);
		rd(A_STAT, rdv);
		chk("overflow", 16'h0041, rdv & 16'h0041);
		rd(A_DATA, rdv);
		chk("kept word", 16'h1234, rdv);
		wr(A_IEN, 16'h0004);
		rd(A_ISTAT, rdv);
		chk("irq enabled", 16'h0001, 16'(irq));
		wr(A_ICLR, 16'h0004);
		rd(A_ISTAT, rdv);
		chk("irq cleared", 16'h0000, 16'(irq));
		// Enhanced mode, master with the clock pin released
		doReset();
		wr(A_MODE, 16'h0001);
		wr(A_CON1, 16'h1420);
		for (int k = 0; k < DEP; k++) begin
			wr(A_DATA, 16'h0a00 + 16'(k));
		end
		wr(A_STAT, 16'h8000);
		rd(A_STAT, rdv);
		rd(A_STAT, rdv);
		chk("tx entry free", 16'h0000, 16'(rdv[B_TBF]));
		chk("clock pin disabled", 16'h0001, 16'(sckOe_n));
		for (int k = 1; k <= DEP; k++) begin
			wr(A_ICLR, 16'h0002);
			pollBit(A_ISTAT, E_RXDATA);
			rd(A_STAT, rdv);
			chk("rx full enh", 16'(k == DEP), 16'(rdv[B_RBF]));
		end
		rd(A_DATA, rdv);
		rd(A_STAT, rdv);
		chk("rx entry free", 16'h0000, 16'(rdv[B_RBF]));
		// Slave mode reports unread receive entries in the count field
		wr(A_CON1, 16'h0400);
		rd(A_STAT, rdv);
		chk("slave rx count", 16'h0003, 16'(rdv[10:8]));
		chk("slave clock pin", 16'h0001, 16'(sckOe_n));
		results();
	end
endmodule
